// [hdl/rmh_rx_filter_regs.sv]
`timescale 1ns/1ps

// Contract
// R01 - 16-bit read/write serial ROM data word.
// R02 - Software reads data word after busy clears.
// R03 - Software loads data before write command.
// R04 - Control bit 0 puts buffer RAM in test.
// R05 - Bit 9 keeps overrun frames, else discard.
// R06 - Bit 11 reads 1 while receive buffer full.
// R07 - Overrun only when data arrives while full; code also flags data arriving while a pending end waits to be pushed.
// R08 - Bit 14 shows transmitting or deferring.
// R09 - Bit 15 shows frame being received.
// R10 - 64-bit table as four words 0x60-0x66.
// R11 - Hash filtering only while enable set.
// R12 - CRC over destination of multicast frames.
// R13 - Low six CRC bits index table.
// R14 - Index 0 word0 LSB, 63 word3 MSB.
// R15 - Set bit accepts frame, clear discards.
// R16 - Busy flag high whole command duration.
// R17 - Overrun frame arrives while buffer full.
// R18 - Unicast or disabled filter never hash-dropped.
module rmh_rx_filter_regs #(
	parameter int DATA_W = rmh_pkg::DATA_W,
	parameter int BYTE_W = 8
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	// Host register port
	input wire logic [rmh_pkg::ADDR_W-1:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [DATA_W-1:0] REG_WDATA_I,
	output logic [DATA_W-1:0] REG_RDATA_O,
	// Serial ROM sequencer side
	input wire logic ROM_BUSY_I,
	input wire logic ROM_LOAD_I,
	input wire logic [DATA_W-1:0] ROM_RD_DATA_I,
	output logic [DATA_W-1:0] ROM_WR_DATA_O,
	// Receive mode and transmitter status
	input wire logic MCAST_FILTER_EN_I,
	input wire logic TX_ACTIVE_I,
	input wire logic TX_DEFER_I,
	output logic BUF_RAM_TEST_O,
	// Incoming frame bytes
	input wire logic RX_VALID_I,
	input wire logic [BYTE_W-1:0] RX_DATA_I,
	input wire logic RX_LAST_I,
	output logic RX_READY_O,
	// Outgoing frame bytes
	output logic FRM_VALID_O,
	output logic [BYTE_W-1:0] FRM_DATA_O,
	output logic FRM_LAST_O,
	output logic FRM_DISCARD_O,
	output logic FRM_OVERRUN_O,
	input wire logic FRM_READY_I
);

	localparam int ENT_W = BYTE_W + 3;
	localparam int CNT_W = $clog2(rmh_pkg::BUF_DEPTH + 1);
	localparam int DA_W = $clog2(rmh_pkg::DA_BYTES + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(rmh_pkg::BUF_DEPTH);
	localparam logic [DA_W-1:0] DA_DONE = DA_W'(rmh_pkg::DA_BYTES);

	logic [DATA_W-1:0] rom_data;
	logic ram_test;
	logic keep_ovf;
	logic [rmh_pkg::HASH_WORDS-1:0][DATA_W-1:0] filter_word;
	logic [rmh_pkg::HASH_WORDS*DATA_W-1:0] filter_table;
	logic [31:0] crc;
	logic [DA_W-1:0] da_cnt;
	logic mcast;
	logic rx_busy;
	logic ovr_seen;
	logic pend_end;
	logic pend_filter;
	logic [rmh_pkg::HASH_IDX_W-1:0] hash_idx;
	logic hash_bit;
	logic filter_drop;
	logic buf_full;
	logic ovr_now;
	logic push;
	logic push_last;
	logic push_discard;
	logic push_ovr;
	logic [BYTE_W-1:0] push_data;
	logic pop;
	logic [rmh_pkg::BUF_DEPTH-1:0][ENT_W-1:0] buf_mem;
	logic [CNT_W-1:0] buf_cnt;
	logic wr_ptr;
	logic rd_ptr;
	logic [ENT_W-1:0] head;
	logic wr_rom;
	logic wr_ctl;
	logic [DATA_W-1:0] next_rdata;

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ rmh_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	assign wr_rom = REG_WR_I && (REG_ADDR_I == rmh_pkg::OFS_ROM_DATA);
	assign wr_ctl = REG_WR_I && (REG_ADDR_I == rmh_pkg::OFS_QUEUE_CTL);

	// A word delivered by the sequencer wins over a host write in the same cycle.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rom_data <= rmh_pkg::RST_WORD;
		end else if (ROM_LOAD_I) begin
			rom_data <= ROM_RD_DATA_I; // R01
		end else if (wr_rom && !ROM_BUSY_I) begin
			rom_data <= REG_WDATA_I; // R16
		end
	end

	assign ROM_WR_DATA_O = rom_data; // R03

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ram_test <= 1'b0;
			keep_ovf <= 1'b0;
		end else if (wr_ctl) begin
			ram_test <= REG_WDATA_I[rmh_pkg::BIT_RAM_TEST]; // R04
			keep_ovf <= REG_WDATA_I[rmh_pkg::BIT_KEEP_OVF]; // R05
		end
	end

	assign BUF_RAM_TEST_O = ram_test; // R04

	// Table words sit at consecutive 16-bit word offsets, two bytes apart, from word 0.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			filter_word <= {rmh_pkg::HASH_WORDS{rmh_pkg::RST_WORD}};
		end else begin
			for (int w = 0; w < rmh_pkg::HASH_WORDS; w++) begin
				if (REG_WR_I && (REG_ADDR_I == rmh_pkg::OFS_FILTER_W0 + 8'(2 * w))) begin
					filter_word[w] <= REG_WDATA_I; // R10
				end
			end
		end
	end

	assign filter_table = filter_word; // R14

	always_comb begin
		next_rdata = '0;
		case (REG_ADDR_I)
			rmh_pkg::OFS_ROM_DATA: begin
				next_rdata = rom_data; // R01
			end
			rmh_pkg::OFS_QUEUE_CTL: begin
				next_rdata[rmh_pkg::BIT_RAM_TEST] = ram_test;
				next_rdata[rmh_pkg::BIT_KEEP_OVF] = keep_ovf;
				next_rdata[rmh_pkg::BIT_RX_FULL] = buf_full; // R06
				next_rdata[rmh_pkg::BIT_TX_ACT] = TX_ACTIVE_I | TX_DEFER_I; // R08
				next_rdata[rmh_pkg::BIT_RX_ACT] = rx_busy | pend_end; // R09
			end
			rmh_pkg::OFS_FILTER_W0: begin
				next_rdata = filter_word[0];
			end
			rmh_pkg::OFS_FILTER_W1: begin
				next_rdata = filter_word[1];
			end
			rmh_pkg::OFS_FILTER_W2: begin
				next_rdata = filter_word[2];
			end
			rmh_pkg::OFS_FILTER_W3: begin
				next_rdata = filter_word[3];
			end
			default: begin
				next_rdata = '0;
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			REG_RDATA_O <= '0;
		end else if (REG_RD_I) begin
			REG_RDATA_O <= next_rdata;
		end
	end

	// Destination address parsing; every arriving byte is seen, even one the buffer refuses.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			crc <= rmh_pkg::CRC_INIT;
			da_cnt <= '0;
			mcast <= 1'b0;
			rx_busy <= 1'b0;
		end else if (RX_VALID_I) begin
			rx_busy <= !RX_LAST_I; // R09
			if (RX_LAST_I) begin
				crc <= rmh_pkg::CRC_INIT;
				da_cnt <= '0;
			end else if (da_cnt != DA_DONE) begin
				crc <= crc_byte(crc, RX_DATA_I); // R12
				da_cnt <= da_cnt + DA_W'(1);
				if (da_cnt == '0) begin
					mcast <= RX_DATA_I[rmh_pkg::MCAST_BIT];
				end
			end
		end
	end

	assign hash_idx = ~crc[rmh_pkg::HASH_IDX_W-1:0]; // R13
	assign hash_bit = filter_table[hash_idx]; // R14
	assign filter_drop = MCAST_FILTER_EN_I && mcast && (da_cnt == DA_DONE) && !hash_bit; // R11 R15 R18

	// Receive buffer occupancy and overrun detection.
	assign buf_full = (buf_cnt == CNT_FULL); // R06
	assign ovr_now = RX_VALID_I && (buf_full || pend_end); // R07 R17
	assign push = !buf_full && (pend_end || RX_VALID_I);
	assign push_last = pend_end || RX_LAST_I;
	assign push_data = pend_end ? '0 : RX_DATA_I;
	assign push_ovr = pend_end || ovr_seen;
	assign push_discard = pend_end ? (pend_filter || !keep_ovf) : (filter_drop || (ovr_seen && !keep_ovf)); // R05 R15
	assign RX_READY_O = !buf_full && !pend_end;

	// A refused last byte leaves a pending end that is pushed as an empty closing entry.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			pend_end <= 1'b0;
			pend_filter <= 1'b0;
		end else if (pend_end && push) begin
			pend_end <= 1'b0;
		end else if (RX_VALID_I && RX_LAST_I && buf_full) begin
			pend_end <= 1'b1; // R17
			pend_filter <= filter_drop;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ovr_seen <= 1'b0;
		end else if (push && push_last) begin
			ovr_seen <= ovr_now && pend_end; // R07
		end else if (ovr_now) begin
			ovr_seen <= 1'b1; // R17
		end
	end

	assign pop = FRM_VALID_O && FRM_READY_I;

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			buf_mem <= '0;
			wr_ptr <= 1'b0;
		end else if (push) begin
			buf_mem[wr_ptr] <= {push_last, push_discard && push_last, push_ovr && push_last, push_data};
			wr_ptr <= !wr_ptr;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rd_ptr <= 1'b0;
			buf_cnt <= '0;
		end else begin
			if (pop) begin
				rd_ptr <= !rd_ptr;
			end
			if (push && !pop) begin
				buf_cnt <= buf_cnt + CNT_W'(1);
			end else if (pop && !push) begin
				buf_cnt <= buf_cnt - CNT_W'(1);
			end
		end
	end

	assign head = buf_mem[rd_ptr];
	assign FRM_VALID_O = (buf_cnt != '0);
	assign FRM_LAST_O = head[BYTE_W+2];
	assign FRM_DISCARD_O = head[BYTE_W+1];
	assign FRM_OVERRUN_O = head[BYTE_W];
	assign FRM_DATA_O = head[BYTE_W-1:0];

	rom_load_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R01
		ROM_LOAD_I |=> rom_data == $past(ROM_RD_DATA_I))
		else $error("Sequencer word not captured.");

	rom_write_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R01
		wr_rom && !ROM_BUSY_I && !ROM_LOAD_I |=> ROM_WR_DATA_O == $past(REG_WDATA_I))
		else $error("Host data word not stored.");

	busy_guard_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R16
		wr_rom && ROM_BUSY_I && !ROM_LOAD_I |=> $stable(rom_data))
		else $error("Data word changed during busy.");

	test_mode_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R04
		wr_ctl |=> BUF_RAM_TEST_O == $past(REG_WDATA_I[rmh_pkg::BIT_RAM_TEST]))
		else $error("Test mode not following control.");

	full_flag_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R06
		REG_RD_I && REG_ADDR_I == rmh_pkg::OFS_QUEUE_CTL |=>
		REG_RDATA_O[rmh_pkg::BIT_RX_FULL] == $past(buf_cnt == CNT_FULL))
		else $error("Full bit wrong.");

	overrun_mark_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R17
		RX_VALID_I && buf_full && !RX_LAST_I |=> ovr_seen)
		else $error("Overrun not marked.");

	full_quiet_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R07
		buf_full && !RX_VALID_I && !ovr_seen |=> !ovr_seen)
		else $error("Full alone flagged overrun.");

	tx_status_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R08
		REG_RD_I && REG_ADDR_I == rmh_pkg::OFS_QUEUE_CTL |=>
		REG_RDATA_O[rmh_pkg::BIT_TX_ACT] == $past(TX_ACTIVE_I || TX_DEFER_I))
		else $error("Transmit indicator wrong.");

	hash_drop_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R15
		push && RX_LAST_I && !pend_end && MCAST_FILTER_EN_I && mcast && da_cnt == DA_DONE && !hash_bit
		|=> buf_mem[$past(wr_ptr)][BYTE_W+1])
		else $error("Hash miss frame not discarded.");

	unicast_pass_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R18
		push && RX_LAST_I && !pend_end && (!mcast || !MCAST_FILTER_EN_I) && !ovr_seen |-> !push_discard)
		else $error("Frame dropped by inactive filter.");

	keep_ovf_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R05
		push && RX_LAST_I && !pend_end && ovr_seen && !filter_drop |-> push_discard == !keep_ovf)
		else $error("Overrun frame handling wrong.");

	table_write_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R10
		REG_WR_I && REG_ADDR_I == rmh_pkg::OFS_FILTER_W3 |=> filter_table[63:48] == $past(REG_WDATA_I))
		else $error("Top table word not stored.");

	stall_hold_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		FRM_VALID_O && !FRM_READY_I |=> FRM_VALID_O && $stable(FRM_DATA_O) && $stable(FRM_LAST_O))
		else $error("Output changed under stall.");

	rx_status_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R09
		RX_VALID_I && !RX_LAST_I |=> rx_busy)
		else $error("Receive indicator not raised.");

	close_entry_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R17
		pend_end && push |=> buf_mem[$past(wr_ptr)][BYTE_W+2] && buf_mem[$past(wr_ptr)][BYTE_W])
		else $error("Closing entry not marked overrun.");

	ready_full_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R06
		buf_full |-> !RX_READY_O)
		else $error("Ready high while buffer full.");

endmodule // rmh_rx_filter_regs

// [pkg/rmh_pkg.sv]
package rmh_pkg;

	// Register port geometry.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// Register byte offsets.
	localparam logic [7:0] OFS_ROM_DATA = 8'h48;
	localparam logic [7:0] OFS_QUEUE_CTL = 8'h4A;
	localparam logic [7:0] OFS_FILTER_W0 = 8'h60;
	localparam logic [7:0] OFS_FILTER_W1 = 8'h62;
	localparam logic [7:0] OFS_FILTER_W2 = 8'h64;
	localparam logic [7:0] OFS_FILTER_W3 = 8'h66;

	// Field positions in queue_control_status.
	localparam int BIT_RAM_TEST = 0;
	localparam int BIT_KEEP_OVF = 9;
	localparam int BIT_RX_FULL = 11;
	localparam int BIT_TX_ACT = 14;
	localparam int BIT_RX_ACT = 15;

	// Reset values.
	localparam logic [15:0] RST_WORD = 16'h0000;

	// Destination address parsing and hashing.
	localparam int DA_BYTES = 6;
	localparam int HASH_IDX_W = 6;
	localparam int HASH_WORDS = 4;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam int MCAST_BIT = 0;

	// Receive buffer depth.
	localparam int BUF_DEPTH = 2;

endpackage

// [verif/rmh_phy_model.sv]
`timescale 1ns/1ps
module rmh_phy_model (
	// Clock
	input wire logic clk_i,
	// Receive byte stream
	output logic valid_o,
	output logic [7:0] data_o,
	output logic last_o
);
	initial begin
		valid_o = 1'b0;
		data_o = 8'h00;
		last_o = 1'b0;
	end
	// The source never waits; between frames the data lines show the inverse of the last byte.
	task automatic send(input logic [7:0] f[$]);
		for (int i = 0; i < f.size(); i++) begin
			@(posedge clk_i);
			#1;
			valid_o = 1'b1;
			data_o = f[i];
			last_o = (i == f.size() - 1);
		end
		@(posedge clk_i);
		#1;
		valid_o = 1'b0;
		last_o = 1'b0;
		data_o = ~data_o;
	endtask
endmodule // rmh_phy_model

// [verif/rmh_rx_filter_regs_tb.sv]
`timescale 1ns/1ps
module rmh_rx_filter_regs_tb;
	logic clk, rst_n, wr, rd, busy, ld, en, txa, txd, rdy, ramt, rv, rl, rr, fv, fl, fd, fo;
	logic [7:0] addr, rx, fdat;
	logic [15:0] wd, rdat, romrd, romwr, w;
	logic [15:0] got[$];
	logic [7:0] f[$];
	logic [7:0] dq[$];
	logic [7:0] ofs[7] = '{rmh_pkg::OFS_FILTER_W0, rmh_pkg::OFS_FILTER_W1, rmh_pkg::OFS_FILTER_W2,
		rmh_pkg::OFS_FILTER_W3, rmh_pkg::OFS_ROM_DATA, rmh_pkg::OFS_QUEUE_CTL, 8'h50};
	logic [63:0] tbl;
	integer seed = 88;
	integer fails = 0;
	integer n_tests = 0;

	rmh_rx_filter_regs dut_u (.CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_WDATA_I(wd), .REG_RDATA_O(rdat), .ROM_BUSY_I(busy), .ROM_LOAD_I(ld), .ROM_RD_DATA_I(romrd),
		.ROM_WR_DATA_O(romwr), .MCAST_FILTER_EN_I(en), .TX_ACTIVE_I(txa), .TX_DEFER_I(txd), .BUF_RAM_TEST_O(ramt),
		.RX_VALID_I(rv), .RX_DATA_I(rx), .RX_LAST_I(rl), .RX_READY_O(rr), .FRM_VALID_O(fv), .FRM_DATA_O(fdat),
		.FRM_LAST_O(fl), .FRM_DISCARD_O(fd), .FRM_OVERRUN_O(fo), .FRM_READY_I(rdy));
	rmh_phy_model phy_u (.clk_i(clk), .valid_o(rv), .data_o(rx), .last_o(rl));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Records every byte and the status of every frame end taken by the consumer.
	always @(posedge clk) begin
		if (fv && rdy) dq.push_back(fdat);
		if (fv && rdy && fl) got.push_back({14'h0000, fd, fo});
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic is_wr, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wd = d;
		wr = is_wr;
		rd = !is_wr;
		@(posedge clk);
		#1;
		wr = 1'b0;
		rd = 1'b0;
	endtask
	function automatic logic [5:0] hidx(input logic [7:0] b[$]);
		logic [31:0] c;
		c = rmh_pkg::CRC_INIT;
		for (int i = 0; i < rmh_pkg::DA_BYTES; i++) begin
			c = c ^ {24'h000000, b[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ rmh_pkg::CRC_POLY) : (c >> 1);
		end
		return ~c[5:0];
	endfunction
	task automatic frame(input logic mc, input logic stall, input logic [15:0] ce);
		f = {};
		for (int i = 0; i < 8; i++) f.push_back(8'($random(seed)));
		f[0][0] = mc;
		got = {};
		dq = {};
		rdy = !stall;
		phy_u.send(f);
		if (stall) begin
			acc(1'b0, rmh_pkg::OFS_QUEUE_CTL, 16'h0000);
			chk(rdat, ce);
			chk({15'h0000, rr}, 16'h0000);
			rdy = 1'b1;
		end
		repeat (8) @(posedge clk);
		#1;
		chk(16'(got.size()), 16'h0001);
		chk(16'(dq.size()), stall ? 16'h0003 : 16'h0008);
		for (int i = 0; i < dq.size(); i++) chk({8'h00, dq[i]}, {8'h00, (stall && i == 2) ? 8'h00 : f[i]});
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#400000;
		fails++;
		print_verdict();
	end
	initial begin
		{rst_n, wr, rd, busy, ld, en, txa, txd, rdy} = 9'h000;
		addr = 8'h00;
		wd = 16'h0000;
		romrd = 16'h0000;
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		for (int i = 0; i < 7; i++) begin
			acc(1'b0, ofs[i], 16'h0000);
			chk(rdat, 16'h0000);
		end
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			w = 16'($random(seed));
			tbl[16 * i +: 16] = w;
			acc(1'b1, 8'(8'h60 + 2 * i), w);
		end
		acc(1'b1, 8'h50, 16'hFFFF);
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, 8'(8'h60 + 2 * i), 16'h0000);
			chk(rdat, tbl[16 * i +: 16]);
		end
		$display("test table done");
		for (int t = 0; t < 4; t++) begin
			{txa, txd} = 2'(t);
			acc(1'b1, rmh_pkg::OFS_QUEUE_CTL, t[0] ? 16'hFFFF : 16'h0000);
			acc(1'b0, rmh_pkg::OFS_QUEUE_CTL, 16'h0000);
			chk(rdat, (t[0] ? 16'h0201 : 16'h0000) | ((t != 0) ? 16'h4000 : 16'h0000));
			chk({15'h0000, ramt}, {15'h0000, t[0]});
		end
		{txa, txd} = 2'b00;
		$display("test control done");
		w = 16'($random(seed));
		acc(1'b1, rmh_pkg::OFS_ROM_DATA, w);
		acc(1'b0, rmh_pkg::OFS_ROM_DATA, 16'h0000);
		chk(rdat, w);
		chk(romwr, w);
		busy = 1'b1;
		acc(1'b1, rmh_pkg::OFS_ROM_DATA, ~w);
		chk(romwr, w);
		@(posedge clk);
		#1;
		ld = 1'b1;
		romrd = ~w ^ 16'h00FF;
		@(posedge clk);
		#1;
		ld = 1'b0;
		busy = 1'b0;
		acc(1'b0, rmh_pkg::OFS_ROM_DATA, 16'h0000);
		chk(rdat, ~w ^ 16'h00FF);
		$display("test rom word done");
		for (int i = 0; i < 32; i++) begin
			en = i[1];
			frame(i[0], 1'b0, 16'h0000);
			chk(got[0], {14'h0000, i[0] & en & !tbl[hidx(f)], 1'b0});
		end
		$display("test hash done");
		for (int k = 0; k < 2; k++) begin
			acc(1'b1, rmh_pkg::OFS_QUEUE_CTL, k[0] ? 16'h0200 : 16'h0000);
			frame(1'b0, 1'b1, k[0] ? 16'h8A00 : 16'h8800);
			chk(got[0], {14'h0000, !k[0], 1'b1});
			acc(1'b0, rmh_pkg::OFS_QUEUE_CTL, 16'h0000);
			chk(rdat, k[0] ? 16'h0200 : 16'h0000);
		end
		$display("test overrun done");
		print_verdict();
	end
endmodule // rmh_rx_filter_regs_tb
